// >>> eil_params.svh
// constants for the external interrupt pin latch block
// assumes an 8-bit register port and a 40 MHz reference clock
`ifndef EIL_PARAMS_SVH
`define EIL_PARAMS_SVH

// register offsets on the plain register port
`define EIL_STATCTL_ADDR    8'h00
`define EIL_INT_STATUS_ADDR 8'h01
`define EIL_INT_ENABLE_ADDR 8'h02

// field positions in the status and control register
`define EIL_MODE_BIT 0
`define EIL_MASK_BIT 1
`define EIL_ACK_BIT  2
`define EIL_PEND_BIT 3

// event positions in the sticky status and enable registers
`define EIL_EV_LATCHED 0
`define EIL_EV_CLEARED 1

// reset values
`define EIL_STATCTL_RESET 8'h00
`define EIL_EVENT_RESET  2'h0
`define EIL_PIN_IDLE     1'b1

// vector pair taken for this interrupt
`define EIL_VECTOR_HI 16'hfffa
`define EIL_VECTOR_LO 16'hfffb

`endif

// >>> eil_pkg.sv
// types for the external interrupt pin latch block
// assumes the constants header is included by the design files
package eil_pkg;

    // whole state of the latch block, registered as one word
    typedef struct packed {
        logic       pin_s1;      // synchroniser stage one
        logic       pin_s2;      // synchroniser stage two
        logic       pin_s3;      // synchroniser stage three
        logic       pin_f;       // agreed pin level
        logic       latch;       // request latch
        logic       ack_seen;    // acknowledge held in level mode
        logic       mask;        // request mask bit
        logic       mode;        // sensitivity select
        logic [1:0] ev_status;   // sticky event bits
        logic [1:0] ev_enable;   // event enables
        logic [7:0] rdata;       // read data register
    } eil_state_t;

endpackage : eil_pkg

// >>> eil_latch.sv
// external interrupt pin latch with status and control register
// assumes one 40 MHz clock, synchronous reset, asynchronous pin
//
// Behaviour
// - falling pin event sets latch until cleared
// - vector fetch acknowledge clears the latch
// - writing one to clear strobe clears latch
// - reset clears latch and sensitivity select
// - edge mode holds until acknowledge, clears immediately
// - level mode clears after acknowledge and pin high
// - mask bit withholds request from priority logic
// - edge after software acknowledge latches again
// - serviced request uses fixed high vector pair
// - pending flag ignores the mask bit
// - pending flag read-only, shows latched request
// - clear strobe write-only, always reads zero
// - mask bit read/write, reset clear, one disables
// - select bit read/write, one adds low level
// - break without enable blocks software clear
// - break with enable clears, stays cleared after
`include "eil_params.svh"

module eil_latch
(
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        irq_pin_n,
    input  wire logic        vector_fetch,
    input  wire logic        break_state,
    input  wire logic        break_clear_enable,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    output logic             irq_request,
    output logic             pending_flag,
    output logic             pin_level,
    output logic      [15:0] vector_hi,
    output logic      [15:0] vector_lo,
    output logic             evt_irq
);

    // address match used by every register access
    function automatic logic addr_hit
    (
        input logic [7:0] addr,
        input logic [7:0] target
    );
        addr_hit = (addr == target);
    endfunction : addr_hit

    eil_pkg::eil_state_t st;
    eil_pkg::eil_state_t next_st;

    logic wr_ctrl;
    logic wr_status;
    logic wr_enable;
    logic sw_ack;
    logic sw_ack_ok;
    logic ack_now;
    logic pin_fall;
    logic clear_cond;
    logic next_latch;

    // register port decode
    assign wr_ctrl   = reg_wr && addr_hit(reg_addr, `EIL_STATCTL_ADDR);
    assign wr_status = reg_wr && addr_hit(reg_addr, `EIL_INT_STATUS_ADDR);
    assign wr_enable = reg_wr && addr_hit(reg_addr, `EIL_INT_ENABLE_ADDR);

    // software acknowledge, gated during break
    assign sw_ack    = wr_ctrl && reg_wdata[`EIL_ACK_BIT];
    assign sw_ack_ok = sw_ack && (!break_state || break_clear_enable);
    assign ack_now   = vector_fetch || sw_ack_ok;

    // falling edge: agreed high, then two agreeing low samples
    assign pin_fall = st.pin_f && !st.pin_s2 && !st.pin_s3;

    // clearing condition depends on sensitivity
    always_comb
    begin
        if (st.mode)
        begin
            clear_cond = (ack_now || st.ack_seen) && st.pin_f;
        end
        else
        begin
            clear_cond = ack_now;
        end
    end

    // set wins over clear, level mode keeps request while low
    assign next_latch = pin_fall
                      || (st.mode && !st.pin_f)
                      || (st.latch && !clear_cond);

    // next state of the whole block
    always_comb
    begin
        next_st = st;
        next_st.pin_s1 = irq_pin_n;
        next_st.pin_s2 = st.pin_s1;
        next_st.pin_s3 = st.pin_s2;
        if (st.pin_s2 == st.pin_s3)
        begin
            next_st.pin_f = st.pin_s3;
        end
        next_st.latch = next_latch;
        // remember an acknowledge until the pin returns high
        if (pin_fall || !next_latch)
        begin
            next_st.ack_seen = 1'b0;
        end
        else if (st.mode && ack_now)
        begin
            next_st.ack_seen = 1'b1;
        end
        // control bits, clear strobe is never stored
        if (wr_ctrl)
        begin
            next_st.mask = reg_wdata[`EIL_MASK_BIT];
            next_st.mode = reg_wdata[`EIL_MODE_BIT];
        end
        // sticky events, write one clears, set wins
        if (wr_status)
        begin
            next_st.ev_status = st.ev_status & ~reg_wdata[1:0];
        end
        if (next_latch && !st.latch)
        begin
            next_st.ev_status[`EIL_EV_LATCHED] = 1'b1;
        end
        if (st.latch && !next_latch)
        begin
            next_st.ev_status[`EIL_EV_CLEARED] = 1'b1;
        end
        if (wr_enable)
        begin
            next_st.ev_enable = reg_wdata[1:0];
        end
        // read data stands only in the cycle after the strobe
        next_st.rdata = 8'h00;
        if (reg_rd)
        begin
            if (addr_hit(reg_addr, `EIL_STATCTL_ADDR))
            begin
                next_st.rdata[`EIL_PEND_BIT] = st.latch;
                next_st.rdata[`EIL_ACK_BIT]  = 1'b0;
                next_st.rdata[`EIL_MASK_BIT] = st.mask;
                next_st.rdata[`EIL_MODE_BIT] = st.mode;
            end
            else if (addr_hit(reg_addr, `EIL_INT_STATUS_ADDR))
            begin
                next_st.rdata[1:0] = st.ev_status;
            end
            else if (addr_hit(reg_addr, `EIL_INT_ENABLE_ADDR))
            begin
                next_st.rdata[1:0] = st.ev_enable;
            end
        end
    end

    // state register, reset clears latch and mode
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            st.pin_s1    <= `EIL_PIN_IDLE;
            st.pin_s2    <= `EIL_PIN_IDLE;
            st.pin_s3    <= `EIL_PIN_IDLE;
            st.pin_f     <= `EIL_PIN_IDLE;
            st.latch     <= 1'b0;
            st.ack_seen  <= 1'b0;
            st.mask      <= 1'b0;
            st.mode      <= 1'b0;
            st.ev_status <= `EIL_EVENT_RESET;
            st.ev_enable <= `EIL_EVENT_RESET;
            st.rdata     <= `EIL_STATCTL_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    // outputs
    assign reg_rdata    = st.rdata;
    assign pending_flag = st.latch;
    assign irq_request  = st.latch && !st.mask;
    assign pin_level    = st.pin_f;
    assign vector_hi    = `EIL_VECTOR_HI;
    assign vector_lo    = `EIL_VECTOR_LO;
    assign evt_irq      = |(st.ev_status & st.ev_enable);

    // checks on the latch behaviour
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    latch_set_a: assert property (
        pin_fall |=> st.latch
    ) else $error("falling edge did not set the latch");

    latch_hold_a: assert property (
        (st.latch && !ack_now && !st.ack_seen) |=> st.latch
    ) else $error("latch dropped without acknowledge");

    vec_clear_a: assert property (
        (vector_fetch && !st.mode && !pin_fall) |=> !st.latch
    ) else $error("vector fetch did not clear latch");

    sw_clear_a: assert property (
        (sw_ack && !break_state && !st.mode && !pin_fall) |=> !st.latch
    ) else $error("software clear did not clear latch");

    reset_clear_a: assert property (
        @(posedge ref_clk) disable iff (1'b0)
        sys_rst |=> (!st.latch && !st.mode && !st.mask)
    ) else $error("reset left latch or mode set");

    level_hold_a: assert property (
        (st.mode && st.latch && !st.pin_f && !sys_rst) |=> st.latch
    ) else $error("level mode released while pin low");

    level_clear_a: assert property (
        (st.mode && st.latch && st.ack_seen && st.pin_f && !pin_fall
         && !(st.mode && !st.pin_f)) |=> !st.latch
    ) else $error("level mode kept latch after ack and high");

    mask_gate_a: assert property (
        (st.mask || !st.latch) |-> !irq_request
    ) else $error("request forwarded while masked");

    new_edge_a: assert property (
        sw_ack ##1 pin_fall |=> st.latch
    ) else $error("edge after acknowledge was lost");

    pend_read_a: assert property (
        (reg_rd && addr_hit(reg_addr, `EIL_STATCTL_ADDR))
        |=> (reg_rdata[`EIL_PEND_BIT] == $past(st.latch))
            && !reg_rdata[`EIL_ACK_BIT]
    ) else $error("pending flag read wrong");

    ctrl_write_a: assert property (
        wr_ctrl |=> (st.mode == $past(reg_wdata[`EIL_MODE_BIT]))
                 && (st.mask == $past(reg_wdata[`EIL_MASK_BIT]))
    ) else $error("control write not stored");

    break_block_a: assert property (
        (sw_ack && break_state && !break_clear_enable && !vector_fetch
         && st.latch && !st.ack_seen) |=> st.latch
    ) else $error("software clear acted during protected break");

    break_clear_a: assert property (
        (sw_ack && break_state && break_clear_enable && !st.mode
         && !pin_fall) |=> !st.latch
    ) else $error("software clear blocked with break enable");

    read_once_a: assert property (
        !reg_rd |=> (reg_rdata == 8'h00)
    ) else $error("read data stood without a read");

    // unmasked latch reaches the priority logic
    irq_fwd_a: assert property (
        (st.latch && !st.mask) |-> irq_request
    ) else $error("unmasked request not forwarded");

    // pending flag visible while masked
    pend_masked_a: assert property (
        (st.latch && st.mask) |-> pending_flag
    ) else $error("pending flag hidden by mask");

    // fixed vector pair
    vector_pair_a: assert property (
        (vector_hi == `EIL_VECTOR_HI)
        && (vector_lo == `EIL_VECTOR_LO)
    ) else $error("vector pair wrong");

    // agreed level moves only when stages agree
    sync_agree_a: assert property (
        (st.pin_s2 != st.pin_s3) |=> (st.pin_f == $past(st.pin_f))
    ) else $error("agreed level moved on disagreement");

    // no request without an event
    no_spurious_a: assert property (
        (!st.latch && !pin_fall
         && !(st.mode && !st.pin_f)) |=> !st.latch
    ) else $error("latch set without pin event");

    // acknowledge kept while pin still low
    level_ack_a: assert property (
        (st.mode && st.latch && ack_now
         && !st.pin_f) |=> st.ack_seen
    ) else $error("level mode lost acknowledge");

    // software clear in level mode with pin high
    sw_level_a: assert property (
        (sw_ack && !break_state && st.mode && st.pin_f
         && !pin_fall) |=> !st.latch
    ) else $error("software clear ignored in level mode");

    // low level sets in level mode
    level_set_a: assert property (
        (st.mode && !st.pin_f) |=> st.latch
    ) else $error("low level did not set latch");

    // protected break still stores control bits
    break_mask_a: assert property (
        (wr_ctrl && break_state && !break_clear_enable)
        |=> (st.mask == $past(reg_wdata[`EIL_MASK_BIT]))
    ) else $error("control bits lost during break");

    // event enable write stored
    enable_write_a: assert property (
        wr_enable |=> (st.ev_enable == $past(reg_wdata[1:0]))
    ) else $error("event enable write lost");

    // write one clears a sticky bit unless set again
    status_clear_a: assert property (
        (wr_status && reg_wdata[`EIL_EV_LATCHED]
         && !(next_latch && !st.latch)) |=> !st.ev_status[`EIL_EV_LATCHED]
    ) else $error("status bit not cleared");

    // latch rise recorded
    set_event_a: assert property (
        (!st.latch ##1 st.latch) |-> st.ev_status[`EIL_EV_LATCHED]
    ) else $error("latch set event missing");

    // latch fall recorded
    clear_event_a: assert property (
        (st.latch ##1 !st.latch) |-> st.ev_status[`EIL_EV_CLEARED]
    ) else $error("latch clear event missing");

    // event interrupt follows enabled status
    evt_level_a: assert property (
        (|(st.ev_status & st.ev_enable)) |-> evt_irq
    ) else $error("event interrupt not raised");

    // unmapped reads give zero
    rd_unmapped_a: assert property (
        (reg_rd && (reg_addr > `EIL_INT_ENABLE_ADDR)) |=> (reg_rdata == 8'h00)
    ) else $error("unmapped read not zero");

endmodule : eil_latch

// >>> eil_pin_model.sv
// pin driver model for the external interrupt input
// assumes the bench asks for a low level on drive_low
module eil_pin_model
(
    input  wire logic drive_low,
    output logic      irq_pin_n
);
    timeunit 1ns;
    timeprecision 100ps;

    // internal pull-up holds the pin high when released
    assign irq_pin_n = drive_low ? 1'b0 : 1'b1;
endmodule : eil_pin_model

// >>> eil_latch_tb_top.sv
// self-checking bench for the external interrupt pin latch
// assumes the constants header and a 40 MHz clock
`include "eil_params.svh"

module eil_latch_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic        ref_clk            = 1'b0;
    logic        sys_rst            = 1'b1;
    logic        drive_low          = 1'b0;
    logic        vector_fetch       = 1'b0;
    logic        break_state        = 1'b0;
    logic        break_clear_enable = 1'b0;
    logic [7:0]  reg_addr           = 8'h00;
    logic [7:0]  reg_wdata          = 8'h00;
    logic        reg_wr             = 1'b0;
    logic        reg_rd             = 1'b0;
    logic        cpu_gmask          = 1'b1;
    logic        irq_pin_n;
    logic [7:0]  reg_rdata;
    logic        irq_request;
    logic        pending_flag;
    logic        pin_level;
    logic [15:0] vector_hi;
    logic [15:0] vector_lo;
    logic        evt_irq;
    int          num_errors         = 0;
    int          num_checks         = 0;
    localparam logic [7:0] ST = `EIL_INT_STATUS_ADDR;
    localparam logic [7:0] EN = `EIL_INT_ENABLE_ADDR;

    // clock at 25 ns period
    always #12.5 ref_clk = ~ref_clk;

    eil_pin_model pin_model (.drive_low(drive_low), .irq_pin_n(irq_pin_n));

    eil_latch dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .irq_pin_n(irq_pin_n),
        .vector_fetch(vector_fetch), .break_state(break_state),
        .break_clear_enable(break_clear_enable), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_request(irq_request),
        .pending_flag(pending_flag), .pin_level(pin_level), .vector_hi(vector_hi),
        .vector_lo(vector_lo), .evt_irq(evt_irq));

    // compare and count
    task chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task flag(input logic seen, input logic exp, input string what);
        chk({15'h0000, seen}, {15'h0000, exp}, what);
    endtask : flag

    task pend(input logic exp);
        flag(pending_flag, exp, "pending_flag");
    endtask : pend

    task tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    // one-cycle register write
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    // one-cycle read, data checked in the following cycle
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk({8'h00, reg_rdata}, {8'h00, exp}, "reg_rdata");
    endtask : rd

    task pin(input logic low, input int n);
        @(posedge ref_clk);
        drive_low <= low;
        tick(n);
    endtask : pin

    task fetch();
        @(posedge ref_clk);
        vector_fetch <= 1'b1;
        @(posedge ref_clk);
        vector_fetch <= 1'b0;
        #1;
    endtask : fetch

    task results();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results

    // watchdog against a hang
    initial
    begin
        #100000;
        num_errors++;
        results();
    end

    // test sequence
    initial
    begin
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(8'h00, 8'h00);
        rd(ST, 8'h00);
        rd(8'h05, 8'h00);
        flag(pin_level, 1'b1, "pin_level");
        chk(vector_hi, 16'hfffa, "vector_hi");
        chk(vector_lo, 16'hfffb, "vector_lo");
        // single-cycle glitch, then edge mode
        pin(1'b1, 0);
        pin(1'b0, 6);
        pend(1'b0);
        pin(1'b1, 6);
        pend(1'b1);
        flag(irq_request, 1'b1, "irq_request");
        flag(irq_request && !cpu_gmask, 1'b0, "cpu_irq");
        rd(8'h00, 8'h08);
        wr(8'h00, 8'h04);
        pend(1'b0);
        rd(8'h00, 8'h00);
        pin(1'b0, 6);
        pin(1'b1, 6);
        pend(1'b1);
        fetch();
        pend(1'b0);
        // masked request still pending
        wr(8'h00, 8'h02);
        pin(1'b0, 6);
        pin(1'b1, 6);
        pend(1'b1);
        flag(irq_request, 1'b0, "irq_request");
        rd(8'h00, 8'h0a);
        wr(8'h00, 8'h04);
        // level mode, acknowledge before and after pin release
        wr(8'h00, 8'h01);
        tick(2);
        pend(1'b1);
        wr(8'h00, 8'h03);
        flag(irq_request, 1'b0, "irq_request");
        fetch();
        tick(2);
        pend(1'b1);
        pin(1'b0, 8);
        pend(1'b0);
        pin(1'b1, 6);
        pin(1'b0, 6);
        pend(1'b1);
        wr(8'h00, 8'h05);
        pend(1'b0);
        // reset with pin held low
        pin(1'b1, 6);
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        tick(3);
        pend(1'b0);
        @(posedge ref_clk);
        sys_rst <= 1'b0;
        tick(1);
        pend(1'b0);
        pin(1'b0, 6);
        rd(8'h00, 8'h08);
        // break state gating of the software clear
        pin(1'b1, 6);
        @(posedge ref_clk);
        break_state <= 1'b1;
        wr(8'h00, 8'h04);
        pend(1'b1);
        @(posedge ref_clk);
        break_clear_enable <= 1'b1;
        wr(8'h00, 8'h04);
        pend(1'b0);
        @(posedge ref_clk);
        break_state        <= 1'b0;
        break_clear_enable <= 1'b0;
        tick(2);
        pend(1'b0);
        // event interrupt raised, masked, cleared
        pin(1'b0, 6);
        wr(ST, 8'h03);
        wr(EN, 8'h01);
        pin(1'b1, 6);
        flag(evt_irq, 1'b1, "evt_irq");
        rd(ST, 8'h01);
        wr(EN, 8'h00);
        flag(evt_irq, 1'b0, "evt_irq");
        wr(EN, 8'h01);
        wr(ST, 8'h01);
        flag(evt_irq, 1'b0, "evt_irq");
        fetch();
        rd(ST, 8'h02);
        rd(EN, 8'h01);
        results();
    end
endmodule : eil_latch_tb_top
